/* verilog/ocp_pg_ctrl.sv */
// Notes on behaviour
// - peak current over upper limit: high side off, low side on.
// - high side stays off until current falls below lower limit.
// - retry protection works only when its enable bit is set; reset clears it.
// - 32 consecutive limited cycles: stop switching 128 us, then soft-start again.
// - entering pause sets retry flag and pulls output good low.
// - detect, pause, retry repeats as long as overload lasts.
// - status read clears retry flag only when no overload is present.
// - retry disabled: limit current every cycle, never pause.
// - retry disabled: capped flag set after four or more consecutive limited cycles.
// - status read clears capped flag only once overload has ended.
// - standalone or primary: good pin is an open-drain status output.
// - secondary: good pin is an input gating discontinuous to continuous mode.
// - window fault when output below 95% or above 105%.
// - window result deglitched about 40 us, delaying good rising edge.
// - blank bit set: ignore window during voltage ramp; else faults pull low.
// - good forced low in shutdown, disabled, lockouts, soft-start, retry mode.
// - secondary presets pulldown latch at init, holding line low, forcing DCM.
// - secondary clears pulldown latch when its start-up completes.
// - secondary sets mode latch on line rise, then runs continuous mode.
// - both secondary latches preset on any disable, shutdown or undervoltage.
`timescale 1ns/1ps
`include "ocp_pg_defines.svh"
`default_nettype none
module ocp_pg_ctrl
    import ocp_pg_pkg::*;
#(
    parameter int unsigned PAUSE_CYC = `PAUSE_US * `CLK_MHZ,
    parameter int unsigned DEG_CYC = `DEGLITCH_US * `CLK_MHZ
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // apb slave
    input wire apb_req_s i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // comparator and pin inputs, asynchronous
    input wire logic i_peak_over,
    input wire logic i_valley_below,
    input wire logic i_window_low,
    input wire logic i_window_high,
    input wire logic i_enable_pin,
    input wire logic i_thermal_shut,
    input wire logic i_input_low_lockout,
    input wire logic i_input_high_lockout,
    input wire logic i_output_good_in,
    input wire logic i_stack_secondary,
    // converter core, same clock
    input wire logic i_pwm_high,
    input wire logic i_cycle_start,
    input wire logic i_soft_start_active,
    input wire logic i_startup_done,
    input wire logic i_voltage_ramp_active,
    // power stage
    output logic o_high_side_on,
    output logic o_low_side_on,
    output logic o_switch_pause,
    output logic o_soft_restart,
    // output good pin and conduction mode
    output logic o_output_good_out,
    output logic o_good_pulldown_oe,
    output logic o_ccm_enable
);

    // ******************************************************
    // helpers
    // ******************************************************

    // two-stage synchroniser shift: bit 0 first stage, bit 1 second
    function automatic logic [1:0] sync2(input logic [1:0] q, input logic d);
        return {q[0], d};
    endfunction : sync2

    // control register reset value, retry and switch enable fields loaded from it at reset
    localparam logic [2:0] CTRL_RST = `CTRL_RESET;

    blk_state_s st_ff;
    blk_state_s nxt_st;

    logic peak;
    logic valley;
    logic en_pin;
    logic tsd;
    logic input_low_lockout;
    logic input_high_lockout;
    logic off_any;
    logic stop_any;
    logic win_fault;
    logic forced_low;
    logic overload;
    logic acc;
    logic done;
    logic rd_clr;
    logic [5:0] streak_inc;

    // synchronised pin levels
    assign peak = st_ff.s_peak[1];
    assign valley = st_ff.s_valley[1];
    assign en_pin = st_ff.s_en[1];
    assign tsd = st_ff.s_tsd[1];
    assign input_low_lockout = st_ff.s_input_low_lockout[1];
    assign input_high_lockout = st_ff.s_input_high_lockout[1];

    // disable sources that preset the secondary latches
    assign off_any = !en_pin || !st_ff.sw_en || tsd || input_low_lockout;
    assign stop_any = off_any || input_high_lockout;
    assign overload = st_ff.capped || (st_ff.streak != 6'h00) || (st_ff.mode == PAUSE_ST);
    assign win_fault = (st_ff.s_wlo[1] || st_ff.s_whi[1])
        && !(st_ff.blank_en && i_voltage_ramp_active);
    assign forced_low = stop_any || i_soft_start_active || st_ff.hic_mode;
    assign streak_inc = (st_ff.streak == 6'h3f) ? st_ff.streak : st_ff.streak + 6'h01;

    // apb access phase and completion
    assign acc = i_apb.psel && i_apb.penable;
    assign done = acc && st_ff.pready;
    assign rd_clr = done && !i_apb.pwrite && (i_apb.paddr == `STAT_OFS);

    // ******************************************************
    // next state
    // ******************************************************

    // all state of the block is computed here
    always_comb begin
        nxt_st = st_ff;
        // synchronisers
        nxt_st.s_peak = sync2(st_ff.s_peak, i_peak_over);
        nxt_st.s_valley = sync2(st_ff.s_valley, i_valley_below);
        nxt_st.s_wlo = sync2(st_ff.s_wlo, i_window_low);
        nxt_st.s_whi = sync2(st_ff.s_whi, i_window_high);
        nxt_st.s_en = sync2(st_ff.s_en, i_enable_pin);
        nxt_st.s_tsd = sync2(st_ff.s_tsd, i_thermal_shut);
        nxt_st.s_input_low_lockout = sync2(st_ff.s_input_low_lockout, i_input_low_lockout);
        nxt_st.s_input_high_lockout = sync2(st_ff.s_input_high_lockout, i_input_high_lockout);
        nxt_st.s_line = sync2(st_ff.s_line, i_output_good_in);
        nxt_st.s_role = sync2(st_ff.s_role, i_stack_secondary);
        nxt_st.line_prev = st_ff.s_line[1];
        nxt_st.restart = 1'b0;

        // role strap caught once the synchroniser holds it
        if (st_ff.init_cnt != 2'h3) begin
            nxt_st.init_cnt = st_ff.init_cnt + 2'h1;
            if (st_ff.init_cnt == 2'h2) begin
                nxt_st.secondary = st_ff.s_role[1];
            end
        end

        // cycle-by-cycle limit latch
        if (peak) begin
            nxt_st.capped = 1'b1;
            nxt_st.hit_cycle = 1'b1;
        end else if (st_ff.capped && valley) begin
            nxt_st.capped = 1'b0;
        end

        // consecutive limited cycle counting at each cycle boundary
        if (i_cycle_start && st_ff.mode == RUN_ST) begin
            nxt_st.hit_cycle = peak;
            if (st_ff.hit_cycle || st_ff.capped) begin
                nxt_st.streak = streak_inc;
            end else begin
                nxt_st.streak = 6'h00;
            end
        end

        // pause sequencer
        unique case (st_ff.mode)
            RUN_ST: begin
                if (st_ff.retry_en && nxt_st.streak >= 6'(`HIC_CYCLES)) begin
                    nxt_st.mode = PAUSE_ST;
                    nxt_st.pause_cnt = 16'(PAUSE_CYC - 1);
                    nxt_st.streak = 6'h00;
                    nxt_st.hic_mode = 1'b1;
                end
            end
            PAUSE_ST: begin
                if (st_ff.pause_cnt == 16'h0000) begin
                    nxt_st.mode = RUN_ST;
                    nxt_st.restart = 1'b1;
                    nxt_st.capped = 1'b0;
                    nxt_st.hit_cycle = 1'b0;
                end else begin
                    nxt_st.pause_cnt = st_ff.pause_cnt - 16'h0001;
                end
            end
        endcase

        // retry mode ends when the restarted output regulates
        if (st_ff.hic_mode && st_ff.mode == RUN_ST && !i_soft_start_active && !win_fault
            && st_ff.streak == 6'h00 && !st_ff.restart) begin
            nxt_st.hic_mode = 1'b0;
        end

        // apb registered answer
        nxt_st.pready = 1'b0;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata = 32'h0000_0000;
        if (acc && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
            unique case (i_apb.paddr)
                `CTRL_OFS: begin
                    nxt_st.prdata[`CTRL_RETRY_BIT] = st_ff.retry_en;
                    nxt_st.prdata[`CTRL_BLANK_BIT] = st_ff.blank_en;
                    nxt_st.prdata[`CTRL_SWEN_BIT] = st_ff.sw_en;
                end
                `STAT_OFS: begin
                    nxt_st.prdata[`STAT_HIC_BIT] = st_ff.hic_flag;
                    nxt_st.prdata[`STAT_CAP_BIT] = st_ff.cap_flag;
                    nxt_st.prdata[`STAT_GOOD_BIT] = st_ff.good;
                    nxt_st.prdata[`STAT_PAUSE_BIT] = st_ff.mode == PAUSE_ST;
                    nxt_st.prdata[`STAT_CCM_BIT] = st_ff.ccm_latch;
                    nxt_st.prdata[`STAT_SEC_BIT] = st_ff.secondary;
                end
                default: begin
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end
        if (done && i_apb.pwrite && i_apb.paddr == `CTRL_OFS) begin
            nxt_st.retry_en = i_apb.pwdata[`CTRL_RETRY_BIT];
            nxt_st.blank_en = i_apb.pwdata[`CTRL_BLANK_BIT];
            nxt_st.sw_en = i_apb.pwdata[`CTRL_SWEN_BIT];
        end

        // sticky flags: read clears only without overload, set wins
        if (rd_clr && !overload) begin
            nxt_st.hic_flag = 1'b0;
            nxt_st.cap_flag = 1'b0;
        end
        if (st_ff.mode == RUN_ST && nxt_st.mode == PAUSE_ST) begin
            nxt_st.hic_flag = 1'b1;
        end
        if (!st_ff.retry_en && nxt_st.streak >= 6'(`CAP_CYCLES)) begin
            nxt_st.cap_flag = 1'b1;
        end

        // deglitch: fault drops good at once, rise waits the filter time
        if (forced_low || win_fault) begin
            nxt_st.deg_cnt = 16'h0000;
            nxt_st.good = 1'b0;
        end else if (!st_ff.good) begin
            if (st_ff.deg_cnt == 16'(DEG_CYC - 1)) begin
                nxt_st.good = 1'b1;
            end else begin
                nxt_st.deg_cnt = st_ff.deg_cnt + 16'h0001;
            end
        end

        // secondary stack handshake latches
        if (off_any) begin
            nxt_st.pull_latch = 1'b1;
            nxt_st.ccm_latch = 1'b0;
        end else begin
            if (i_startup_done) begin
                nxt_st.pull_latch = 1'b0;
            end
            if (st_ff.s_line[1] && !st_ff.line_prev && !st_ff.pull_latch) begin
                nxt_st.ccm_latch = 1'b1;
            end
        end

        // power stage and pin drive
        nxt_st.hs = i_pwm_high && !nxt_st.capped && nxt_st.mode == RUN_ST && !stop_any;
        nxt_st.ls = (!i_pwm_high || nxt_st.capped) && nxt_st.mode == RUN_ST && !stop_any;
        if (st_ff.secondary) begin
            nxt_st.pd_oe = nxt_st.pull_latch;
            nxt_st.ccm = nxt_st.ccm_latch;
        end else begin
            nxt_st.pd_oe = !nxt_st.good;
            nxt_st.ccm = 1'b1;
        end
    end

    // ******************************************************
    // state register
    // ******************************************************

    // synchronous reset; latches preset for discontinuous mode
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            st_ff <= '0;
            st_ff.retry_en <= CTRL_RST[`CTRL_RETRY_BIT];
            st_ff.sw_en <= CTRL_RST[`CTRL_SWEN_BIT];
            st_ff.pull_latch <= 1'b1;
            st_ff.pd_oe <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops, except the good output tied low
    assign o_prdata = st_ff.prdata;
    assign o_pready = st_ff.pready;
    assign o_pslverr = st_ff.pslverr;
    assign o_high_side_on = st_ff.hs;
    assign o_low_side_on = st_ff.ls;
    assign o_switch_pause = st_ff.mode == PAUSE_ST;
    assign o_soft_restart = st_ff.restart;
    assign o_output_good_out = 1'b0; // open drain only pulls low
    assign o_good_pulldown_oe = st_ff.pd_oe;
    assign o_ccm_enable = st_ff.ccm;

    // ******************************************************
    // assertions
    // ******************************************************

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_cap_hs_off: assert property (st_ff.capped |-> !o_high_side_on)
        else $error("high side on while capped");
    a_cap_hold: assert property (st_ff.capped && !valley && !peak |=> st_ff.capped)
        else $error("cap released above lower limit");
    a_retry_off: assert property (!st_ff.retry_en && st_ff.mode == RUN_ST |=> st_ff.mode == RUN_ST)
        else $error("pause without retry enable");
    a_pause_entry: assert property ($rose(o_switch_pause) |-> st_ff.hic_flag
        && st_ff.pause_cnt == 16'(PAUSE_CYC - 1))
        else $error("pause entry wrong");
    a_pause_exit: assert property (st_ff.mode == PAUSE_ST && st_ff.pause_cnt == 16'h0000
        |=> !o_switch_pause && o_soft_restart)
        else $error("pause exit wrong");
    a_hic_good_low: assert property (st_ff.hic_mode |=> !st_ff.good)
        else $error("good high in retry mode");
    a_cap_flag_set: assert property (!st_ff.retry_en && st_ff.streak >= 6'h04 |-> st_ff.cap_flag)
        else $error("capped flag missing");
    a_flag_keep: assert property (rd_clr && overload && st_ff.cap_flag |=> st_ff.cap_flag)
        else $error("capped flag cleared under overload");
    a_hic_keep: assert property (rd_clr && overload && st_ff.hic_flag |=> st_ff.hic_flag)
        else $error("retry flag cleared under overload");
    a_forced_low: assert property (forced_low |=> !st_ff.good)
        else $error("good not forced low");
    a_good_rise: assert property ($rose(st_ff.good) |-> $past(st_ff.deg_cnt) == 16'(DEG_CYC - 1))
        else $error("good rose before deglitch");
    a_preset: assert property (off_any |=> st_ff.pull_latch && !st_ff.ccm_latch)
        else $error("latches not preset");
    a_pd_sec: assert property (st_ff.secondary && st_ff.pull_latch |-> o_good_pulldown_oe)
        else $error("secondary not pulling down");

    // stage, counting and handshake checks
    a_hs_ls_excl: assert property (!(o_high_side_on && o_low_side_on))
        else $error("both switches on");
    a_restart_pulse: assert property (o_soft_restart |=> !o_soft_restart)
        else $error("restart pulse too long");
    a_pause_idle: assert property (o_switch_pause |-> !o_high_side_on && !o_low_side_on)
        else $error("switching during pause");
    a_pause_flag: assert property (o_switch_pause |-> st_ff.hic_flag)
        else $error("retry flag lost during pause");
    a_streak_reset: assert property (i_cycle_start && st_ff.mode == RUN_ST && !st_ff.hit_cycle && !st_ff.capped |=> st_ff.streak == 6'h00)
        else $error("streak kept after clean cycle");
    a_good_drop: assert property (win_fault |=> !st_ff.good)
        else $error("good high with window fault");
    a_blank_keep: assert property (st_ff.blank_en && i_voltage_ramp_active && !forced_low && st_ff.good |=> st_ff.good)
        else $error("good dropped while blanked");
    a_pull_release: assert property (!off_any && i_startup_done |=> !st_ff.pull_latch)
        else $error("pulldown latch not released");
    a_ccm_set: assert property (!off_any && !st_ff.pull_latch && st_ff.s_line[1] && !st_ff.line_prev |=> st_ff.ccm_latch)
        else $error("mode latch not set on line rise");
    a_ccm_primary: assert property (!st_ff.secondary |=> o_ccm_enable)
        else $error("primary not in continuous mode");
    a_pd_primary: assert property (!st_ff.secondary |=> o_good_pulldown_oe == !st_ff.good)
        else $error("primary pulldown not following good");

    c_pause: cover property ($rose(o_switch_pause));
    c_cap_flag: cover property ($rose(st_ff.cap_flag));
    c_good: cover property ($rose(st_ff.good));
    c_ccm: cover property ($rose(st_ff.ccm_latch));
    c_hic_flag: cover property ($rose(st_ff.hic_flag));

endmodule : ocp_pg_ctrl
`default_nettype wire

/* verilog/ocp_pg_defines.svh */
`ifndef OCP_PG_DEFINES_SVH
`define OCP_PG_DEFINES_SVH
// register offsets (byte addresses)
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
// control register fields
`define CTRL_RETRY_BIT 0
`define CTRL_BLANK_BIT 1
`define CTRL_SWEN_BIT 2
`define CTRL_RESET 3'h4
// status register fields
`define STAT_HIC_BIT 0
`define STAT_CAP_BIT 1
`define STAT_GOOD_BIT 2
`define STAT_PAUSE_BIT 3
`define STAT_CCM_BIT 4
`define STAT_SEC_BIT 5
// timing
`define CLK_MHZ 250
`define PAUSE_US 128
`define DEGLITCH_US 40
`define HIC_CYCLES 32
`define CAP_CYCLES 4
`endif

/* verilog/ocp_pg_pkg.sv */
`default_nettype none
package ocp_pg_pkg;
    typedef enum logic {RUN_ST, PAUSE_ST} run_e;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // complete state of the block
    typedef struct packed {
        logic [1:0] s_peak;
        logic [1:0] s_valley;
        logic [1:0] s_wlo;
        logic [1:0] s_whi;
        logic [1:0] s_en;
        logic [1:0] s_tsd;
        logic [1:0] s_input_low_lockout;
        logic [1:0] s_input_high_lockout;
        logic [1:0] s_line;
        logic [1:0] s_role;
        logic line_prev;
        logic [1:0] init_cnt;
        logic secondary;
        logic retry_en;
        logic blank_en;
        logic sw_en;
        logic capped;
        logic hit_cycle;
        logic [5:0] streak;
        run_e mode;
        logic [15:0] pause_cnt;
        logic hic_mode;
        logic restart;
        logic hic_flag;
        logic cap_flag;
        logic [15:0] deg_cnt;
        logic good;
        logic pull_latch;
        logic ccm_latch;
        logic hs;
        logic ls;
        logic pd_oe;
        logic ccm;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } blk_state_s;
endpackage : ocp_pg_pkg
`default_nettype wire

/* verification/ocp_pg_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// power stage and modulator model
// ****************************************
module ocp_pg_stage_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // overload request from the bench, switch levels from the block
    input wire logic i_overload,
    input wire logic i_high_side_on,
    input wire logic i_switch_pause,
    input wire logic i_soft_restart,
    // comparator and modulator levels
    output logic o_peak_over,
    output logic o_valley_below,
    output logic o_pwm_high,
    output logic o_cycle_start,
    output logic o_soft_start_active
);
    logic [3:0] phase_ff;
    logic [2:0] fall_ff;
    logic [4:0] ss_ff;
    logic ol_ff;

    // 16-clock switching cycle; overload is latched once per cycle so counts are exact
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            phase_ff <= 4'h0;
            fall_ff <= 3'h0;
            ss_ff <= 5'h0;
            ol_ff <= 1'b0;
        end else begin
            phase_ff <= phase_ff + 4'h1;
            if (phase_ff == 4'hf) begin
                ol_ff <= i_overload;
            end
            fall_ff <= i_high_side_on ? 3'h0 : ((fall_ff == 3'h7) ? fall_ff : fall_ff + 3'h1);
            ss_ff <= i_soft_restart ? 5'h14 : ((ss_ff != 5'h0) ? ss_ff - 5'h1 : ss_ff);
        end
    end

    // overloaded current trips the upper limit while the high side conducts
    assign o_peak_over = ol_ff & i_high_side_on & ~i_switch_pause;
    // current sinks below the lower limit three clocks after the high side opens
    assign o_valley_below = ~ol_ff | (fall_ff >= 3'h3);
    assign o_cycle_start = (phase_ff == 4'h0) & ~i_rst;
    assign o_pwm_high = (phase_ff < 4'h8) & ~i_switch_pause;
    assign o_soft_start_active = ss_ff != 5'h0;
endmodule : ocp_pg_stage_model
`default_nettype wire

/* verification/overcurrent_and_power_good_logic_bench.sv */
`timescale 1ns/1ps
`include "ocp_pg_defines.svh"
`default_nettype none
// ****************************************
// bench top
// ****************************************
module overcurrent_and_power_good_logic_bench;
    import ocp_pg_pkg::*;
    localparam int unsigned PAUSE_N = 20;
    localparam int unsigned DEG_N = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    apb_req_s apb = '0;
    logic [31:0] prdata;
    logic pready, pslverr, peak, valley, pwm, cyc, ss_m, hs, ls, pause, restart, pd_oe, ccm, good_out;
    logic overload = 1'b0, win_lo = 1'b0, win_hi = 1'b0, ramp = 1'b0;
    logic secondary = 1'b0, done = 1'b1, other_pull = 1'b0;
    logic [4:0] force_v = 5'h0; // thermal, low lockout, high lockout, disable, soft start
    logic [5:0] mon;
    logic [64:0] note;
    logic [64:0] exp_q[$]; // error, mask, value
    int n_mismatch = 0;
    int compares = 0;
    int k, cnt;

    always #2 clk = ~clk;
    assign mon = {peak, ccm, pd_oe, pause, ls, hs};

    ocp_pg_ctrl #(.PAUSE_CYC(PAUSE_N), .DEG_CYC(DEG_N)) i_ocp_pg_ctrl (
        .i_ref_clk(clk), .i_rst(rst), .i_apb(apb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_peak_over(peak), .i_valley_below(valley), .i_window_low(win_lo), .i_window_high(win_hi),
        .i_enable_pin(~force_v[3]), .i_thermal_shut(force_v[0]), .i_input_low_lockout(force_v[1]),
        .i_input_high_lockout(force_v[2]), .i_output_good_in(~pd_oe & ~other_pull),
        .i_stack_secondary(secondary), .i_pwm_high(pwm), .i_cycle_start(cyc),
        .i_soft_start_active(ss_m | force_v[4]), .i_startup_done(done), .i_voltage_ramp_active(ramp),
        .o_high_side_on(hs), .o_low_side_on(ls), .o_switch_pause(pause), .o_soft_restart(restart),
        .o_output_good_out(good_out), .o_good_pulldown_oe(pd_oe), .o_ccm_enable(ccm));

    ocp_pg_stage_model i_ocp_pg_stage_model (
        .i_ref_clk(clk), .i_rst(rst), .i_overload(overload), .i_high_side_on(hs), .i_switch_pause(pause),
        .i_soft_restart(restart), .o_peak_over(peak), .o_valley_below(valley), .o_pwm_high(pwm),
        .o_cycle_start(cyc), .o_soft_start_active(ss_m));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic clocks(input int n);
        repeat (n) @(posedge clk);
    endtask : clocks

    // bounded wait for one watched output to reach a level, sampled on the falling edge
    task automatic wait_bit(input int idx, input logic lvl, input int bound);
        int n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (mon[idx] !== lvl && n < bound);
        if (mon[idx] !== lvl) begin
            n_mismatch++;
            $display("BAD t=%0t wait ran out on output %0d", $time, idx);
            tally_and_finish();
        end
    endtask : wait_bit

    // apb transfer: setup, access held until pready is seen, expectation queued for the monitor
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                            input logic [31:0] exp, input logic [31:0] mask, input logic err);
        int n = 0;
        exp_q.push_back({err, mask, exp});
        @(posedge clk);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("BAD t=%0t no pready", $time);
            tally_and_finish();
        end
        @(posedge clk);
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask : apb_xfer

    // monitor: each answered access is compared with the oldest queued note
    always @(negedge clk) begin
        if (pready === 1'b1) begin
            note = (exp_q.size() > 0) ? exp_q.pop_front() : {1'b1, 64'h0};
            check(prdata & note[63:32], note[31:0]);
            check({31'h0, pslverr}, {31'h0, note[64]});
        end
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h92b3));
        clocks(16);
        rst <= 1'b0;
        clocks(30);
        apb_xfer(1'b0, `CTRL_OFS, 32'h0, 32'h4, 32'h7, 1'b0);
        apb_xfer(1'b0, 8'h3c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        wait_bit(3, 1'b0, 100);
        check({31'h0, ccm}, 32'h1);
        check({31'h0, good_out}, 32'h0);
        // window fault and deglitched release
        @(posedge clk);
        win_lo <= 1'b1;
        wait_bit(3, 1'b1, 10);
        @(posedge clk);
        win_lo <= 1'b0;
        repeat (4) @(negedge clk);
        check({31'h0, pd_oe}, 32'h1);
        wait_bit(3, 1'b0, 40);
        // ramp blanking on, then off
        apb_xfer(1'b1, `CTRL_OFS, ($urandom() & 32'hfffffff8) | 32'h6, 32'h0, 32'h0, 1'b0);
        apb_xfer(1'b0, `CTRL_OFS, 32'h0, 32'h6, 32'h7, 1'b0);
        ramp <= 1'b1;
        win_hi <= 1'b1;
        repeat (20) @(negedge clk);
        check({31'h0, pd_oe}, 32'h0);
        apb_xfer(1'b1, `CTRL_OFS, 32'h4, 32'h0, 32'h0, 1'b0);
        wait_bit(3, 1'b1, 10);
        @(posedge clk);
        ramp <= 1'b0;
        win_hi <= 1'b0;
        wait_bit(3, 1'b0, 40);
        // thermal, both lockouts, disable pin and soft start each pull good low
        for (k = 0; k < 5; k++) begin
            @(posedge clk);
            force_v <= 5'h1 << k;
            wait_bit(3, 1'b1, 10);
            @(posedge clk);
            force_v <= 5'h0;
            wait_bit(3, 1'b0, 80);
        end
        // current-limit mode: long overload, no pause
        @(posedge clk);
        overload <= 1'b1;
        wait_bit(5, 1'b1, 40);
        repeat (5) @(negedge clk);
        check({30'h0, ls, hs}, 32'h2);
        repeat (3) @(negedge clk);
        check({31'h0, hs}, 32'h0);
        cnt = 0;
        repeat (16 * (34 + $urandom_range(6))) begin
            @(negedge clk);
            cnt += (pause === 1'b1) ? 1 : 0;
        end
        check(cnt, 0);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h2, 32'h2, 1'b0);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h2, 32'h2, 1'b0);
        overload <= 1'b0;
        clocks(64);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h2, 32'h2, 1'b0);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h0, 32'h2, 1'b0);
        // three limited, one clean, three limited: no flag
        overload <= 1'b1;
        clocks(48);
        overload <= 1'b0;
        clocks(16);
        overload <= 1'b1;
        clocks(48);
        overload <= 1'b0;
        clocks(64);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h0, 32'h2, 1'b0);
        // retry mode: detect, pause, restart, repeat
        apb_xfer(1'b1, `CTRL_OFS, 32'h5, 32'h0, 32'h0, 1'b0);
        overload <= 1'b1;
        repeat (16 * 30) @(negedge clk);
        check({31'h0, pause}, 32'h0);
        wait_bit(2, 1'b1, 16 * 6);
        @(negedge clk);
        check({31'h0, pd_oe}, 32'h1);
        cnt = 1;
        do begin
            cnt++;
            @(negedge clk);
        end while (pause === 1'b1 && cnt < 100);
        check(cnt, PAUSE_N);
        wait_bit(2, 1'b1, 16 * 40);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h1, 32'h1, 1'b0);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h1, 32'h1, 1'b0);
        overload <= 1'b0;
        wait_bit(2, 1'b0, 100);
        clocks(200);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h1, 32'h1, 1'b0);
        apb_xfer(1'b0, `STAT_OFS, 32'h0, 32'h0, 32'h1, 1'b0);
        wait_bit(3, 1'b0, 100);
        // secondary role after a fresh reset
        @(posedge clk);
        secondary <= 1'b1;
        done <= 1'b0;
        other_pull <= 1'b1;
        rst <= 1'b1;
        clocks(16);
        rst <= 1'b0;
        repeat (10) @(negedge clk);
        check({30'h0, pd_oe, ccm}, 32'h2);
        @(posedge clk);
        done <= 1'b1;
        wait_bit(3, 1'b0, 10);
        repeat (10) @(negedge clk);
        check({31'h0, ccm}, 32'h0);
        @(posedge clk);
        other_pull <= 1'b0;
        wait_bit(4, 1'b1, 10);
        @(posedge clk);
        force_v <= 5'h8;
        wait_bit(4, 1'b0, 10);
        wait_bit(3, 1'b1, 10);
        check(exp_q.size(), 0);
        tally_and_finish();
    end
endmodule : overcurrent_and_power_good_logic_bench
`default_nettype wire
